// ==== rtl/gpio_exp_cfg.svh ====
// constants for the two-wire gpio expander front end
`ifndef GPIO_EXP_CFG_SVH
`define GPIO_EXP_CFG_SVH
`define GX_ADDR_BASE 7'h20
`define GX_NPINS 16
`define GX_CMD_IN0 3'h0
`define GX_CMD_IN1 3'h1
`define GX_CMD_OUT0 3'h2
`define GX_CMD_OUT1 3'h3
`define GX_CMD_POL0 3'h4
`define GX_CMD_POL1 3'h5
`define GX_CMD_CFG0 3'h6
`define GX_CMD_CFG1 3'h7
`define GX_OUT_RST 16'hFFFF
`define GX_POL_RST 16'h0000
`define GX_CFG_RST 16'hFFFF
`define GX_BIT_LAST 3'h7
`endif

// ==== rtl/gpio_exp_pkg.sv ====
// types for the two-wire gpio expander front end
package gpio_exp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_RX = 3'h2,
    ST_RACK = 3'h6,
    ST_TX = 3'h7,
    ST_TACK = 3'h5
  } link_state_e;
  typedef logic [2:0] reg_idx_t;
endpackage

// ==== rtl/gpio_exp_reg_if.sv ====
// carrier between the serial front end and the register store
`timescale 1ns/1ps
`default_nettype none
interface gpio_exp_reg_if;
  logic soft_rst;
  logic wr;
  logic [2:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic snap;
  logic [15:0] pins;
  logic [15:0] out_val;
  logic [15:0] dir_in;
  logic [15:0] in_snap;
  modport front (output soft_rst, wr, idx, wdata, snap, pins,
                 input rdata, out_val, dir_in, in_snap);
  modport store (input soft_rst, wr, idx, wdata, snap, pins,
                 output rdata, out_val, dir_in, in_snap);
endinterface
`default_nettype wire

// ==== rtl/gpio_exp_regs.sv ====
// register store: output, polarity, direction and input snapshot
`timescale 1ns/1ps
`default_nettype none
`include "gpio_exp_cfg.svh"
module gpio_exp_regs
  import gpio_exp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  gpio_exp_reg_if.store rb
);
  logic [15:0] out_q, out_d, pol_q, pol_d, cfg_q, cfg_d, snap_q, snap_d;
  logic [7:0] rdata_q, rdata_d;
  logic [15:0] in_now;

  // input levels as software sees them, after optional inversion
  assign in_now = rb.pins ^ pol_q;

  // writes land in the byte that idx names; bit n is pin n of the group
  always_comb begin
    out_d = out_q;
    pol_d = pol_q;
    cfg_d = cfg_q;
    snap_d = snap_q;
    if (rb.wr) begin
      case (rb.idx)
        `GX_CMD_OUT0: out_d[7:0] = rb.wdata;
        `GX_CMD_OUT1: out_d[15:8] = rb.wdata;
        `GX_CMD_POL0: pol_d[7:0] = rb.wdata;
        `GX_CMD_POL1: pol_d[15:8] = rb.wdata;
        `GX_CMD_CFG0: cfg_d[7:0] = rb.wdata;
        `GX_CMD_CFG1: cfg_d[15:8] = rb.wdata;
        default: ; // input bytes ignore writes
      endcase
    end
    // a read of an input byte rearms the change alert for that group
    if (rb.snap && rb.idx == `GX_CMD_IN0) snap_d[7:0] = rb.pins[7:0];
    if (rb.snap && rb.idx == `GX_CMD_IN1) snap_d[15:8] = rb.pins[15:8];
    if (rb.soft_rst) begin
      out_d = `GX_OUT_RST;
      pol_d = `GX_POL_RST;
      cfg_d = `GX_CFG_RST;
      snap_d = rb.pins;
    end
  end

  // registered read data
  always_comb begin
    case (rb.idx)
      `GX_CMD_IN0: rdata_d = in_now[7:0];
      `GX_CMD_IN1: rdata_d = in_now[15:8];
      `GX_CMD_OUT0: rdata_d = out_q[7:0];
      `GX_CMD_OUT1: rdata_d = out_q[15:8];
      `GX_CMD_POL0: rdata_d = pol_q[7:0];
      `GX_CMD_POL1: rdata_d = pol_q[15:8];
      `GX_CMD_CFG0: rdata_d = cfg_q[7:0];
      default: rdata_d = cfg_q[15:8];
    endcase
  end

  // defaults on power-up: every pin an input
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q <= `GX_OUT_RST;
      pol_q <= `GX_POL_RST;
      cfg_q <= `GX_CFG_RST;
      snap_q <= 16'h0000;
      rdata_q <= 8'h00;
    end else begin
      out_q <= out_d;
      pol_q <= pol_d;
      cfg_q <= cfg_d;
      snap_q <= snap_d;
      rdata_q <= rdata_d;
    end
  end

  assign rb.rdata = rdata_q;
  assign rb.out_val = out_q;
  assign rb.dir_in = cfg_q;
  assign rb.in_snap = snap_q;
endmodule // gpio_exp_regs
`default_nettype wire

// ==== rtl/gpio_exp_top.sv ====
// serial slave front end and pin drivers of a 16-pin gpio expander
`timescale 1ns/1ps
`default_nettype none
`include "gpio_exp_cfg.svh"
module gpio_exp_top
  import gpio_exp_pkg::*;
#(
  parameter int NPINS = `GX_NPINS
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  input wire logic addr_strap_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic [NPINS-1:0] port_i,
  output logic [NPINS-1:0] port_o,
  output logic [NPINS-1:0] port_oe_n_o,
  output logic [NPINS-1:0] high_side_driver_o,
  output logic [NPINS-1:0] low_side_driver_o,
  output logic alert_o,
  output logic alert_oe_n_o
);
  gpio_exp_reg_if rb ();

  // two-flop synchronisers; a third stage on the bus lines finds edges
  logic [3:0] s1_q, s2_q;
  logic scl_q3, sda_q3;
  logic [NPINS-1:0] pin1_q, pin2_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 4'hF;
      s2_q <= 4'hF;
      scl_q3 <= 1'b1;
      sda_q3 <= 1'b1;
      pin1_q <= '0;
      pin2_q <= '0;
    end else begin
      s1_q <= {reset_n_i, addr_strap_i, scl_i, sda_i};
      s2_q <= s1_q;
      scl_q3 <= s2_q[1];
      sda_q3 <= s2_q[0];
      pin1_q <= port_i;
      pin2_q <= pin1_q;
    end
  end

  logic scl, sda, strap, soft_rst;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign sda = s2_q[0];
  assign scl = s2_q[1];
  assign strap = s2_q[2];
  assign soft_rst = ~s2_q[3];
  assign scl_rise = scl & ~scl_q3;
  assign scl_fall = ~scl & scl_q3;
  // data moving while clock stays high is a control event, not data
  assign start_ev = scl & scl_q3 & ~sda & sda_q3;
  assign stop_ev = scl & scl_q3 & sda & ~sda_q3;

  // bus machine state
  link_state_e st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic rw_q, rw_d, hold_q, hold_d, first_q, first_d, acked_q, acked_d;
  logic got_q, got_d; // eight bits shifted in, waiting for the closing fall
  reg_idx_t cmd_q, cmd_d;
  logic wr_d, snap_d;
  logic [6:0] own_addr;

  // strap is trusted stable for the whole transfer, so read it live
  assign own_addr = `GX_ADDR_BASE | {6'h00, strap};

  // next-state logic of the serial slave
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rw_d = rw_q;
    hold_d = hold_q;
    first_d = first_q;
    acked_d = acked_q;
    got_d = got_q;
    cmd_d = cmd_q;
    wr_d = 1'b0;
    snap_d = 1'b0;
    if (start_ev) begin
      st_d = ST_ADDR;
      cnt_d = 3'h0;
      hold_d = 1'b0;
      got_d = 1'b0;
    end else if (stop_ev) begin
      st_d = ST_IDLE;
      hold_d = 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 3'h1;
            // the fall that closes a start must not pass for a full byte
            if (cnt_q == `GX_BIT_LAST) got_d = 1'b1;
          end
          if (scl_fall && got_q) begin
            got_d = 1'b0;
            if (st_q == ST_RX) begin
              hold_d = 1'b1;
              st_d = ST_RACK;
              if (first_q) cmd_d = reg_idx_t'(sh_q[2:0]);
              else wr_d = 1'b1;
            end else if (sh_q[7:1] == own_addr) begin
              hold_d = 1'b1;
              rw_d = sh_q[0];
              st_d = ST_AACK;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            hold_d = 1'b0;
            st_d = ST_RX;
            // data after the command byte alternates within the pair
            if (!first_q) cmd_d = cmd_q ^ 3'h1;
            first_d = 1'b0;
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            cnt_d = 3'h0;
            if (rw_q) begin
              sh_d = rb.rdata;
              hold_d = ~rb.rdata[7];
              snap_d = 1'b1;
              st_d = ST_TX;
            end else begin
              hold_d = 1'b0;
              first_d = 1'b1;
              st_d = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            cnt_d = cnt_q + 3'h1;
            sh_d = {sh_q[6:0], 1'b0};
            if (cnt_q == `GX_BIT_LAST) begin
              hold_d = 1'b0;
              st_d = ST_TACK;
            end else begin
              hold_d = ~sh_q[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            acked_d = ~sda;
            if (!sda) cmd_d = cmd_q ^ 3'h1;
          end
          if (scl_fall) begin
            cnt_d = 3'h0;
            if (acked_q) begin
              sh_d = rb.rdata;
              hold_d = ~rb.rdata[7];
              snap_d = 1'b1;
              st_d = ST_TX;
            end else begin
              hold_d = 1'b0;
              st_d = ST_IDLE;
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
          hold_d = 1'b0;
        end
      endcase
    end
    if (soft_rst) begin
      st_d = ST_IDLE;
      hold_d = 1'b0;
      got_d = 1'b0;
      cmd_d = `GX_CMD_IN0;
      wr_d = 1'b0;
      snap_d = 1'b0;
    end
  end

  // bus machine registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      hold_q <= 1'b0;
      first_q <= 1'b0;
      acked_q <= 1'b0;
      got_q <= 1'b0;
      cmd_q <= `GX_CMD_IN0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rw_q <= rw_d;
      hold_q <= hold_d;
      first_q <= first_d;
      acked_q <= acked_d;
      got_q <= got_d;
      cmd_q <= cmd_d;
    end
  end

  assign rb.soft_rst = soft_rst;
  assign rb.wr = wr_d;
  assign rb.idx = (cmd_d == cmd_q) ? cmd_q : cmd_d;
  assign rb.wdata = sh_q;
  assign rb.snap = snap_d;
  assign rb.pins = pin2_q;

  gpio_exp_regs u_regs (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .rb(rb)
  );

  // pin driver next values, one slice per pin
  logic [NPINS-1:0] hs_d, ls_d;
  logic [NPINS-1:0] hs_q, ls_q, oe_n_q, pv_q;
  logic alert_q, sda_oe_n_q;
  genvar g;
  for (g = 0; g < NPINS; g++) begin : g_pin
    assign hs_d[g] = ~rb.dir_in[g] & rb.out_val[g];
    assign ls_d[g] = ~rb.dir_in[g] & ~rb.out_val[g];
  end

  // registered pin, alert and data-line drive; open-drain enables low to drive
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_q <= '0;
      ls_q <= '0;
      oe_n_q <= '1;
      pv_q <= '0;
      alert_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else begin
      hs_q <= hs_d;
      ls_q <= ls_d;
      oe_n_q <= rb.dir_in;
      pv_q <= rb.out_val;
      // alert releases once levels match the last read snapshot
      alert_q <= ~|((pin2_q ^ rb.in_snap) & rb.dir_in);
      sda_oe_n_q <= ~hold_q;
    end
  end

  // the data line is only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe_n_o = sda_oe_n_q;
  assign port_o = pv_q;
  assign port_oe_n_o = oe_n_q;
  assign high_side_driver_o = hs_q;
  assign low_side_driver_o = ls_q;
  assign alert_o = 1'b0;
  assign alert_oe_n_o = alert_q;
endmodule // gpio_exp_top
`default_nettype wire

// ==== dv/gpio_exp_props.sv ====
// concurrent checks on the gpio expander top ports
`timescale 1ns/1ps
`default_nettype none
module gpio_exp_props #(
  parameter int NPINS = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  input wire logic addr_strap_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic [NPINS-1:0] port_i,
  input wire logic [NPINS-1:0] port_o,
  input wire logic [NPINS-1:0] port_oe_n_o,
  input wire logic [NPINS-1:0] high_side_driver_o,
  input wire logic [NPINS-1:0] low_side_driver_o,
  input wire logic alert_o,
  input wire logic alert_oe_n_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // pin controls quiet long enough for the drivers to catch up
  sequence steady_s;
    ($stable(port_o) && $stable(port_oe_n_o)) [*3];
  endsequence
  // master lets data rise while clock high
  sequence stop_s;
    scl_i && $rose(sda_i);
  endsequence
  a_sda_pull_only: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  a_alert_pull_only: assert property (alert_o == 1'b0)
    else $error("alert line driven high");
  a_input_undriven: assert property (((high_side_driver_o | low_side_driver_o) & port_oe_n_o) == '0)
    else $error("input pin has a driver on");
  a_output_follows: assert property (steady_s |-> (high_side_driver_o == (~port_oe_n_o & port_o)) && (low_side_driver_o == (~port_oe_n_o & ~port_o)))
    else $error("output drivers disagree with stored value");
  a_por_inputs: assert property ($fell(rst_i) |-> (&port_oe_n_o) && !(|high_side_driver_o) && !(|low_side_driver_o))
    else $error("pins not inputs after power-on");
  a_pin_reset_dirs: assert property ((!reset_n_i) [*5] |-> (&port_oe_n_o) && sda_oe_n_o)
    else $error("reset pin low but defaults not held");
  a_sda_change_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("device changed data while clock high");
  a_stop_release: assert property (stop_s |-> sda_oe_n_o [*8])
    else $error("data pulled after stop");
endmodule // gpio_exp_props
`default_nettype wire

// ==== dv/gpio_exp_master.sv ====
// two-wire bus master model driving the expander's serial lines
`timescale 1ns/1ps
`default_nettype none
module gpio_exp_master (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // both lines released, bus idle
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // five clocks low and four high, a 90 ns bus clock; the device answers four clocks after a fall
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask
  // data set in clock low, sampled at the end of clock high
  task automatic bit_x(input logic b, output logic r);
    @(posedge clk_i);
    sda_low_o <= !b;
    half();
    scl_o <= 1'b1;
    half();
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  // only called with the bus idle
  task automatic start();
    half();
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    @(posedge clk_i);
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_low_o <= 1'b0;
    half();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask
  // last byte left high, earlier ones acknowledged
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule // gpio_exp_master
`default_nettype wire

// ==== dv/gpio_exp_top_tb.sv ====
// testbench for the gpio expander top with a bus master model
`timescale 1ns/1ps
`default_nettype none
module gpio_exp_top_tb;
  logic sys_clk_i, rst_i, reset_n_i, addr_strap_i, scl, m_low, sda_w;
  logic sda_o, sda_oe_n_o, alert_o, alert_oe_n_o;
  logic [15:0] ext_q, pins, port_o, port_oe_n_o, hs, ls, exp_pins;
  logic [7:0] rd0, rd1;
  int fail_count = 0;
  int n_compared = 0;
  // pull-up on data; either side may only pull low
  assign sda_w = !m_low && (sda_oe_n_o || sda_o);
  // pin level is the design's drive where it drives, else the outside
  assign pins = (port_oe_n_o & ext_q) | (~port_oe_n_o & port_o);
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  gpio_exp_top i_gpio_exp_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
    .addr_strap_i(addr_strap_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .port_i(pins), .port_o(port_o), .port_oe_n_o(port_oe_n_o),
    .high_side_driver_o(hs), .low_side_driver_o(ls), .alert_o(alert_o),
    .alert_oe_n_o(alert_oe_n_o));
  gpio_exp_master i_gpio_exp_master (.clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(m_low));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  function automatic logic [7:0] adr(input logic rw);
    return {(addr_strap_i ? 7'h21 : 7'h20), rw};
  endfunction
  task automatic put(input logic [7:0] b, input logic exp_ack);
    logic a;
    i_gpio_exp_master.wr_byte(b, a);
    check(16'(a), 16'(exp_ack));
  endtask
  // command then a pair of data bytes, each acknowledged
  task automatic wr_regs(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
    i_gpio_exp_master.start();
    put(adr(1'b0), 1'b0);
    put(cmd, 1'b0);
    put(d0, 1'b0);
    put(d1, 1'b0);
    i_gpio_exp_master.stop();
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    reset_n_i = 1'b1;
    addr_strap_i = 1'b0;
    // pin 15 low, so a byte sent after the final nack would pull data low
    ext_q = 16'h1E61;
    settle(20);
    check(port_oe_n_o, 16'hFFFF);
    check(hs | ls, 16'h0000);
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    settle(4);
    check(port_o, 16'hFFFF);
    i_gpio_exp_master.start();
    put(8'h42, 1'b1);
    i_gpio_exp_master.stop();
    wr_regs(8'h06, 8'h0F, 8'hF0);
    wr_regs(8'h02, 8'hA5, 8'h3C);
    settle(4);
    check(port_oe_n_o, 16'hF00F);
    check(hs, 16'h0CA0);
    check(ls, 16'h0350);
    // point at the input pair, then read it back in a fresh transfer
    i_gpio_exp_master.start();
    put(adr(1'b0), 1'b0);
    put(8'h00, 1'b0);
    i_gpio_exp_master.stop();
    i_gpio_exp_master.start();
    put(adr(1'b1), 1'b0);
    i_gpio_exp_master.rd_byte(1'b0, rd0);
    i_gpio_exp_master.rd_byte(1'b1, rd1);
    settle(7);
    check(16'(sda_oe_n_o), 16'h0001);
    i_gpio_exp_master.stop();
    exp_pins = (16'hF00F & ext_q) | (16'h0FF0 & 16'h3CA5);
    check({rd1, rd0}, exp_pins);
    settle(4);
    check(16'(alert_oe_n_o), 16'h0001);
    @(posedge sys_clk_i);
    ext_q <= ext_q ^ 16'h0001;
    settle(6);
    check(16'(alert_oe_n_o), 16'h0000);
    @(posedge sys_clk_i);
    ext_q <= ext_q ^ 16'h0001;
    settle(6);
    check(16'(alert_oe_n_o), 16'h0001);
    // strap moves only between transfers
    @(posedge sys_clk_i);
    addr_strap_i <= 1'b1;
    settle(4);
    i_gpio_exp_master.start();
    put(8'h40, 1'b1);
    i_gpio_exp_master.stop();
    wr_regs(8'h06, 8'h00, 8'h00);
    settle(4);
    check(hs, 16'h3CA5);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    settle(8);
    check(port_oe_n_o, 16'hFFFF);
    check(hs | ls, 16'h0000);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    settle(4);
    check(port_o, 16'hFFFF);
    print_verdict();
  end
  // whole run is some 1760 clocks
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    print_verdict();
  end
endmodule // gpio_exp_top_tb
bind gpio_exp_top gpio_exp_props #(.NPINS(NPINS)) i_gpio_exp_props (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .reset_n_i(reset_n_i), .addr_strap_i(addr_strap_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .port_i(port_i), .port_o(port_o),
  .port_oe_n_o(port_oe_n_o), .high_side_driver_o(high_side_driver_o),
  .low_side_driver_o(low_side_driver_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o));
`default_nettype wire
